// file: verilog/epiu_pkg.sv
// external pin interrupt unit: shared offsets, field positions, codes
// assumes an 8-bit register port and one 100 MHz system clock
package epiu_pkg;

   // ----------------------------------------------------------------
   // register offsets
   // ----------------------------------------------------------------
   localparam logic [7:0] OFS_PCHG_MASK0  = 8'h0f;
   localparam logic [7:0] OFS_PCHG_MASK1  = 8'h10;
   localparam logic [7:0] OFS_PCHG_FLAGS  = 8'h11;
   localparam logic [7:0] OFS_PCHG_ENABLE = 8'h12;
   localparam logic [7:0] OFS_EXT_MASK    = 8'h13;
   localparam logic [7:0] OFS_EXT_FLAGS   = 8'h14;
   localparam logic [7:0] OFS_EXT_SENSE   = 8'h15;
   localparam logic [7:0] OFS_EVT_STATUS  = 8'h16;
   localparam logic [7:0] OFS_EVT_MASK    = 8'h17;

   // ----------------------------------------------------------------
   // reset values and field positions
   // ----------------------------------------------------------------
   localparam logic [7:0] RST_BYTE        = 8'h00;
   localparam int         BIT_EXT_ZERO    = 0;  // mask / flag bit
   localparam int         BIT_GRP0        = 0;  // group enable / flag
   localparam int         BIT_GRP1        = 1;
   localparam int         GRP0_LINES      = 8;
   localparam int         GRP1_LINES      = 4;
   localparam int         ALL_LINES       = GRP0_LINES + GRP1_LINES;
   localparam int         EVT_BITS        = 3;  // ext, grp0, grp1

   // ----------------------------------------------------------------
   // sense codes for the dedicated line
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {
      SENSE_LOW  = 2'h0,
      SENSE_ANY  = 2'h1,
      SENSE_FALL = 2'h2,
      SENSE_RISE = 2'h3
   } epiu_sense_t;

   // ----------------------------------------------------------------
   // vector codes presented with a service request
   // ----------------------------------------------------------------
   localparam logic [1:0] VEC_NONE        = 2'h0;
   localparam logic [1:0] VEC_EXT_ZERO    = 2'h1;
   localparam logic [1:0] VEC_PCHG_ZERO   = 2'h2;
   localparam logic [1:0] VEC_PCHG_ONE    = 2'h3;

endpackage : epiu_pkg

// file: verilog/epiu_top.sv
// external pin interrupt unit: dedicated line plus twelve pin-change
// lines, flags, enables, vectored request and a wake indication
// assumes pins already synchronous to clk_sys_i and a cpu that
// pulses svc_ack_i with the vector it is about to run
//
// Notes on behaviour
// - sense code 00 low level, 01 any change, 10 falling, 11 rising
// - dedicated line sampled first; pulses over one clock caught in the edge and change modes
// - dedicated request only with global enable and own mask; own vector
// - line activity requests even when the pin drives as output
// - edge or change on dedicated line sets its flag
// - flags clear on service or by writing a one
// - dedicated flag held clear while level sensing selected
// - group one: unmasked change on lines 11..8 requests, own vector
// - group zero: unmasked change on lines 7..0 requests, own vector
// - change on lines 11..8 sets group one flag; jump when enabled
// - change on lines 7..0 sets group zero flag; jump when enabled
// - group zero mask at 0x0f, reset zero, one bit per line
// - group one mask at 0x10, bits 3..0 gate lines 11..8
// - pin changes detected for wake only while clk_sys_i runs
// - dedicated edges never wake; an unmasked low level wakes, also only with the clock
module epiu_top #(
   parameter int ADDR_W = 8
) (
   input  wire logic                              clk_sys_i,
   input  wire logic                              rst_i,
   input  wire logic [ADDR_W-1:0]                 reg_addr_i,
   input  wire logic [7:0]                        reg_wdata_i,
   input  wire logic                              reg_wr_i,
   input  wire logic                              reg_rd_i,
   output logic      [7:0]                        reg_rdata_o,
   input  wire logic                              ext_line_zero_i,
   input  wire logic [epiu_pkg::ALL_LINES-1:0]    pinchg_line_i,
   input  wire logic                              global_int_enable_i,
   input  wire logic                              svc_ack_i,
   input  wire logic [1:0]                        svc_vector_i,
   output logic                                   int_req_o,
   output logic      [1:0]                        int_vector_o,
   output logic                                   irq_o,
   output logic                                   wake_o
);

   // ----------------------------------------------------------------
   // elaboration checks
   // ----------------------------------------------------------------
   if (ADDR_W < 5 || ADDR_W > 8) begin : g_bad_addr
      $error("epiu_top: ADDR_W must lie between 5 and 8");
   end

   // ----------------------------------------------------------------
   // registers
   // ----------------------------------------------------------------
   logic [7:0]                        pchg_mask0_q;
   logic [3:0]                        pchg_mask1_q;
   logic [1:0]                        pchg_en_q;
   logic [1:0]                        pchg_flag_q;
   logic [1:0]                        pchg_flag_d;
   logic                              ext_mask_q;
   logic                              ext_flag_q;
   logic                              ext_flag_d;
   epiu_pkg::epiu_sense_t             sense_q;
   logic [epiu_pkg::EVT_BITS-1:0]     evt_status_q;
   logic [epiu_pkg::EVT_BITS-1:0]     evt_status_d;
   logic [epiu_pkg::EVT_BITS-1:0]     evt_mask_q;
   logic                              ext_smp_q;
   logic                              ext_prev_q;
   logic [epiu_pkg::ALL_LINES-1:0]    pin_smp_q;
   logic [epiu_pkg::ALL_LINES-1:0]    pin_prev_q;
   logic [1:0]                        prime_q;
   logic [7:0]                        rdata_q;
   logic                              int_req_q;
   logic [1:0]                        int_vec_q;
   logic                              irq_q;
   logic                              wake_q;

   // ----------------------------------------------------------------
   // address decode
   // ----------------------------------------------------------------
   wire [7:0] addr8      = 8'(reg_addr_i);
   wire       wr_mask0   = reg_wr_i && addr8 == epiu_pkg::OFS_PCHG_MASK0;
   wire       wr_mask1   = reg_wr_i && addr8 == epiu_pkg::OFS_PCHG_MASK1;
   wire       wr_pflags  = reg_wr_i && addr8 == epiu_pkg::OFS_PCHG_FLAGS;
   wire       wr_pen     = reg_wr_i && addr8 == epiu_pkg::OFS_PCHG_ENABLE;
   wire       wr_emask   = reg_wr_i && addr8 == epiu_pkg::OFS_EXT_MASK;
   wire       wr_eflags  = reg_wr_i && addr8 == epiu_pkg::OFS_EXT_FLAGS;
   wire       wr_sense   = reg_wr_i && addr8 == epiu_pkg::OFS_EXT_SENSE;
   wire       wr_estat   = reg_wr_i && addr8 == epiu_pkg::OFS_EVT_STATUS;
   wire       wr_evmask  = reg_wr_i && addr8 == epiu_pkg::OFS_EVT_MASK;

   // ----------------------------------------------------------------
   // sampling and transition detection
   // ----------------------------------------------------------------
   // prime_q hides the first compare after reset, where the previous
   // sample is a reset constant and not a real pin level
   wire       primed     = prime_q[1];
   wire       ext_rise   = primed && ext_smp_q && !ext_prev_q;
   wire       ext_fall   = primed && !ext_smp_q && ext_prev_q;
   wire [epiu_pkg::ALL_LINES-1:0] pin_chg;

   // one change detector per pin-change line
   for (genvar i = 0; i < epiu_pkg::ALL_LINES; i++) begin : g_chg
      assign pin_chg[i] = primed && (pin_smp_q[i] ^ pin_prev_q[i]);
   end

   // sample every pin once, then keep the previous sample
   // no direction input: an output-driven pin is seen like any other
   always_ff @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) begin
         ext_smp_q  <= 1'b1;
         ext_prev_q <= 1'b1;
         pin_smp_q  <= '0;
         pin_prev_q <= '0;
         prime_q    <= 2'h0;
      end else begin
         ext_smp_q  <= ext_line_zero_i;
         ext_prev_q <= ext_smp_q;
         pin_smp_q  <= pinchg_line_i;
         pin_prev_q <= pin_smp_q;
         prime_q    <= {prime_q[0], 1'b1};
      end
   end

   // ----------------------------------------------------------------
   // dedicated line trigger selection
   // ----------------------------------------------------------------
   wire sense_low  = sense_q == epiu_pkg::SENSE_LOW;
   wire ext_hit    = (sense_q == epiu_pkg::SENSE_ANY  && (ext_rise || ext_fall))
                   || (sense_q == epiu_pkg::SENSE_FALL && ext_fall)
                   || (sense_q == epiu_pkg::SENSE_RISE && ext_rise);
   // level request follows the sampled pin; it vanishes when the pin
   // rises, so a short low may never be serviced
   wire ext_level  = sense_low && !ext_smp_q;

   // ----------------------------------------------------------------
   // pin-change group hits
   // ----------------------------------------------------------------
   wire [1:0] grp_hit;
   assign grp_hit[0] = |(pin_chg[7:0] & pchg_mask0_q);
   assign grp_hit[1] = |(pin_chg[11:8] & pchg_mask1_q);

   // ----------------------------------------------------------------
   // flag clears: write-one or service of the matching vector
   // ----------------------------------------------------------------
   wire ack_ext   = svc_ack_i && svc_vector_i == epiu_pkg::VEC_EXT_ZERO;
   wire ack_g0    = svc_ack_i && svc_vector_i == epiu_pkg::VEC_PCHG_ZERO;
   wire ack_g1    = svc_ack_i && svc_vector_i == epiu_pkg::VEC_PCHG_ONE;
   wire clr_ext   = ack_ext
                  || (wr_eflags && reg_wdata_i[epiu_pkg::BIT_EXT_ZERO]);
   wire [1:0] clr_grp;
   assign clr_grp[0] = ack_g0
                     || (wr_pflags && reg_wdata_i[epiu_pkg::BIT_GRP0]);
   assign clr_grp[1] = ack_g1
                     || (wr_pflags && reg_wdata_i[epiu_pkg::BIT_GRP1]);

   // next flag values; a hit in the clearing cycle wins over the clear
   assign ext_flag_d  = sense_low ? 1'b0
                      : (ext_hit || (ext_flag_q && !clr_ext));
   assign pchg_flag_d = grp_hit | (pchg_flag_q & ~clr_grp);

   // ----------------------------------------------------------------
   // vectored request, fixed priority by vector number
   // ----------------------------------------------------------------
   wire req_ext = global_int_enable_i && ext_mask_q
                && (sense_low ? ext_level : ext_flag_q);
   wire req_g0  = global_int_enable_i && pchg_en_q[epiu_pkg::BIT_GRP0]
                && pchg_flag_q[0];
   wire req_g1  = global_int_enable_i && pchg_en_q[epiu_pkg::BIT_GRP1]
                && pchg_flag_q[1];
   wire [1:0] vec_sel = req_ext ? epiu_pkg::VEC_EXT_ZERO
                      : req_g0  ? epiu_pkg::VEC_PCHG_ZERO
                      : req_g1  ? epiu_pkg::VEC_PCHG_ONE
                      : epiu_pkg::VEC_NONE;

   // ----------------------------------------------------------------
   // event status for the summary interrupt line
   // ----------------------------------------------------------------
   wire [epiu_pkg::EVT_BITS-1:0] evt_set = {grp_hit, ext_hit && !sense_low};
   wire [epiu_pkg::EVT_BITS-1:0] evt_clr =
      wr_estat ? reg_wdata_i[epiu_pkg::EVT_BITS-1:0] : '0;
   assign evt_status_d = evt_set | (evt_status_q & ~evt_clr);

   // wake: registered here, so a stopped-clock wake needs the same
   // terms rebuilt from raw pins in the always-on domain
   wire wake_d = (ext_mask_q && ext_level) || (|grp_hit);

   // ----------------------------------------------------------------
   // read mux; unmapped addresses and reserved bits read zero
   // ----------------------------------------------------------------
   wire [7:0] rd_mux =
        addr8 == epiu_pkg::OFS_PCHG_MASK0  ? pchg_mask0_q
      : addr8 == epiu_pkg::OFS_PCHG_MASK1  ? {4'h0, pchg_mask1_q}
      : addr8 == epiu_pkg::OFS_PCHG_FLAGS  ? {6'h00, pchg_flag_q}
      : addr8 == epiu_pkg::OFS_PCHG_ENABLE ? {6'h00, pchg_en_q}
      : addr8 == epiu_pkg::OFS_EXT_MASK    ? {7'h00, ext_mask_q}
      : addr8 == epiu_pkg::OFS_EXT_FLAGS   ? {7'h00, ext_flag_q}
      : addr8 == epiu_pkg::OFS_EXT_SENSE   ? {6'h00, sense_q}
      : addr8 == epiu_pkg::OFS_EVT_STATUS  ? {5'h00, evt_status_q}
      : addr8 == epiu_pkg::OFS_EVT_MASK    ? {5'h00, evt_mask_q}
      : epiu_pkg::RST_BYTE;

   // ----------------------------------------------------------------
   // software-written control registers
   // ----------------------------------------------------------------
   always_ff @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) begin
         pchg_mask0_q <= epiu_pkg::RST_BYTE;
         pchg_mask1_q <= 4'h0;
         pchg_en_q    <= 2'h0;
         ext_mask_q   <= 1'b0;
         sense_q      <= epiu_pkg::SENSE_LOW;
         evt_mask_q   <= '0;
      end else begin
         if (wr_mask0)  pchg_mask0_q <= reg_wdata_i;
         if (wr_mask1)  pchg_mask1_q <= reg_wdata_i[3:0];
         if (wr_pen)    pchg_en_q    <= reg_wdata_i[1:0];
         if (wr_emask)  ext_mask_q   <= reg_wdata_i[0];
         if (wr_sense)  sense_q      <=
            epiu_pkg::epiu_sense_t'(reg_wdata_i[1:0]);
         if (wr_evmask) evt_mask_q   <= reg_wdata_i[epiu_pkg::EVT_BITS-1:0];
      end
   end

   // ----------------------------------------------------------------
   // flags, status and registered outputs
   // ----------------------------------------------------------------
   always_ff @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) begin
         ext_flag_q   <= 1'b0;
         pchg_flag_q  <= 2'h0;
         evt_status_q <= '0;
         rdata_q      <= epiu_pkg::RST_BYTE;
         int_req_q    <= 1'b0;
         int_vec_q    <= epiu_pkg::VEC_NONE;
         irq_q        <= 1'b0;
         wake_q       <= 1'b0;
      end else begin
         ext_flag_q   <= ext_flag_d;
         pchg_flag_q  <= pchg_flag_d;
         evt_status_q <= evt_status_d;
         rdata_q      <= reg_rd_i ? rd_mux : epiu_pkg::RST_BYTE;
         int_req_q    <= vec_sel != epiu_pkg::VEC_NONE;
         int_vec_q    <= vec_sel;
         irq_q        <= |(evt_status_d & evt_mask_q);
         wake_q       <= wake_d;
      end
   end

   assign reg_rdata_o  = rdata_q;
   assign int_req_o    = int_req_q;
   assign int_vector_o = int_vec_q;
   assign irq_o        = irq_q;
   assign wake_o       = wake_q;

   // ----------------------------------------------------------------
   // assertions
   // ----------------------------------------------------------------
   default clocking cb_sys @(posedge clk_sys_i);
   endclocking
   default disable iff (rst_i);

   a_sample_first: assert property (
      ##1 ext_smp_q == $past(ext_line_zero_i))
      else $error("dedicated line sample lags by other than one clock");

   a_level_no_flag: assert property (
      sense_low |=> !ext_flag_q)
      else $error("dedicated flag set while level sensing");

   a_rise_sets: assert property (
      sense_q == epiu_pkg::SENSE_RISE && primed && ext_smp_q && !ext_prev_q
      |=> ext_flag_q)
      else $error("rising edge did not set the dedicated flag");

   a_fall_sets: assert property (
      sense_q == epiu_pkg::SENSE_FALL && primed && !ext_smp_q && ext_prev_q
      |=> ext_flag_q)
      else $error("falling edge did not set the dedicated flag");

   a_pulse_caught: assert property (
      sense_q == epiu_pkg::SENSE_ANY && primed && $stable(sense_q)
      && !ext_flag_q && !clr_ext ##1 ext_smp_q != ext_prev_q
      |=> ext_flag_q)
      else $error("change on dedicated line was missed");

   a_ext_w1c: assert property (
      wr_eflags && reg_wdata_i[0] && !ext_hit |=> !ext_flag_q)
      else $error("write one did not clear the dedicated flag");

   a_grp_ack_clr: assert property (
      ack_g1 && !grp_hit[1] |=> !pchg_flag_q[1])
      else $error("service did not clear group one flag");

   a_grp0_sets: assert property (
      primed && |((pin_smp_q[7:0] ^ pin_prev_q[7:0]) & pchg_mask0_q)
      |=> pchg_flag_q[0])
      else $error("unmasked change did not set group zero flag");

   a_grp1_masked: assert property (
      pchg_mask1_q == 4'h0 && !pchg_flag_q[1] |=> !pchg_flag_q[1])
      else $error("group one flag set with all lines masked");

   a_req_needs_gie: assert property (
      int_req_o |-> $past(global_int_enable_i))
      else $error("request raised without global enable");

   a_level_vector: assert property (
      sense_low && ext_mask_q && global_int_enable_i && !ext_smp_q
      |=> int_req_o && int_vector_o == epiu_pkg::VEC_EXT_ZERO)
      else $error("low level did not request on its own vector");

   a_grp1_vector: assert property (
      req_g1 && !req_ext && !req_g0
      |=> int_req_o && int_vector_o == epiu_pkg::VEC_PCHG_ONE)
      else $error("group one flag did not request its vector");

   c_rise_flag: cover property (
      sense_q == epiu_pkg::SENSE_RISE ##1 ext_flag_q);
   c_grp1_served: cover property (
      int_vector_o == epiu_pkg::VEC_PCHG_ONE ##[1:4] ack_g1);
   c_level_req: cover property (
      sense_low && int_req_o);
   c_set_beats_clr: cover property (
      grp_hit[0] && clr_grp[0]);

endmodule : epiu_top

// file: sim/epiu_pin_model.sv
// pin model: outside circuitry on the dedicated line and the twelve
// pin-change lines; assumes the bench calls its tasks between edges
module epiu_pin_model (
   input  wire logic                           clk_sys_i,
   output logic                                ext_line_o,
   output logic [epiu_pkg::ALL_LINES-1:0]      lines_o
);
   timeunit 1ns;
   timeprecision 100ps;

   // ----------------------------------------------------------------
   // driven levels
   // ----------------------------------------------------------------
   // idle high on the dedicated line so a low is a deliberate request
   initial begin
      ext_line_o = 1'b1;
      lines_o    = '0;
   end

   // a level lands just after an edge and holds until the next call,
   // so even a one-cycle pulse spans a sampling edge
   // a low level stays until the caller lifts it
   task automatic set_ext(input logic v);
      @(posedge clk_sys_i);
      ext_line_o <= v;
   endtask : set_ext

   // one toggle of one pin-change line
   task automatic toggle_line(input int n);
      @(posedge clk_sys_i);
      lines_o[n] <= ~lines_o[n];
   endtask : toggle_line
endmodule : epiu_pin_model

// file: sim/epiu_top_tb_top.sv
// bench: register tasks, pin model and service pulses around epiu_top
// assumes the design answers reads one cycle after the strobe
module epiu_top_tb_top;
   timeunit 1ns;
   timeprecision 100ps;

   logic        clk_sys_i, rst_i, wr, rd, gie, ack, ext_line;
   logic [7:0]  addr, wdata, rdata;
   logic [11:0] pins;
   logic [1:0]  svc_vec, int_vec;
   logic        int_req, irq, wake;
   int          err_total, samples_checked, cycles;

   epiu_top epiu_top_inst (
      .clk_sys_i           (clk_sys_i),
      .rst_i               (rst_i),
      .reg_addr_i          (addr),
      .reg_wdata_i         (wdata),
      .reg_wr_i            (wr),
      .reg_rd_i            (rd),
      .reg_rdata_o         (rdata),
      .ext_line_zero_i     (ext_line),
      .pinchg_line_i       (pins),
      .global_int_enable_i (gie),
      .svc_ack_i           (ack),
      .svc_vector_i        (svc_vec),
      .int_req_o           (int_req),
      .int_vector_o        (int_vec),
      .irq_o               (irq),
      .wake_o              (wake)
   );

   epiu_pin_model epiu_pin_model_inst (
      .clk_sys_i           (clk_sys_i),
      .ext_line_o          (ext_line),
      .lines_o             (pins)
   );

   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         err_total++;
         $display("mismatch at %0t: seen 0x%0h expected 0x%0h",
                  $time, seen, exp);
      end
   endtask : check

   task automatic complete_run();
      $display("checks %0d, mismatches %0d", samples_checked, err_total);
      if (err_total == 0 && samples_checked > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask : complete_run

   task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk_sys_i);
      addr  <= a;
      wdata <= d;
      wr    <= 1'b1;
      @(posedge clk_sys_i);
      wr    <= 1'b0;
   endtask : reg_write

   // read data stand only in the cycle after the strobe
   task automatic reg_check(input logic [7:0] a, input logic [7:0] exp);
      @(posedge clk_sys_i);
      addr <= a;
      rd   <= 1'b1;
      @(posedge clk_sys_i);
      rd   <= 1'b0;
      #1;
      check(rdata, exp);
   endtask : reg_check

   task automatic service(input logic [1:0] v);
      @(posedge clk_sys_i);
      ack     <= 1'b1;
      svc_vec <= v;
      @(posedge clk_sys_i);
      ack     <= 1'b0;
   endtask : service

   // pin to request takes three edges; six leaves margin
   task automatic settle();
      repeat (6) @(posedge clk_sys_i);
      #1;
   endtask : settle

   task automatic req_check(input logic r, input logic [1:0] v);
      check({7'h00, int_req}, {7'h00, r});
      check({6'h00, int_vec}, {6'h00, v});
   endtask : req_check

   // ----------------------------------------------------------------
   // clock, reset, watchdog
   // ----------------------------------------------------------------
   initial begin
      clk_sys_i = 1'b0;
      forever #5 clk_sys_i = ~clk_sys_i;
   end

   // the whole sequence needs well under a thousand cycles
   always @(posedge clk_sys_i) begin
      cycles++;
      if (cycles == 4000) begin
         err_total++;
         complete_run();
      end
   end

   // ----------------------------------------------------------------
   // main sequence
   // ----------------------------------------------------------------
   initial begin
      logic fall_hit, rise_hit;
      rst_i = 1'b1;
      {wr, rd, gie, ack} = 4'h0;
      addr = 8'h00;
      wdata = 8'h00;
      svc_vec = 2'h0;
      {err_total, samples_checked, cycles} = '0;
      repeat (10) @(posedge clk_sys_i);
      rst_i <= 1'b0;
      // masks: reset values, access, reserved bits, unmapped place
      reg_check(epiu_pkg::OFS_PCHG_MASK0, 8'h00);
      reg_check(epiu_pkg::OFS_PCHG_MASK1, 8'h00);
      reg_write(epiu_pkg::OFS_PCHG_MASK0, 8'ha5);
      reg_check(epiu_pkg::OFS_PCHG_MASK0, 8'ha5);
      reg_write(epiu_pkg::OFS_PCHG_MASK1, 8'hff);
      reg_check(epiu_pkg::OFS_PCHG_MASK1, 8'h0f);
      reg_write(8'h30, 8'hff);
      reg_check(8'h30, 8'h00);
      // low level requests at once and never sets the flag
      reg_write(epiu_pkg::OFS_EXT_MASK, 8'h01);
      gie <= 1'b1;
      epiu_pin_model_inst.set_ext(1'b0);
      settle();
      req_check(1'b1, epiu_pkg::VEC_EXT_ZERO);
      check({7'h00, wake}, 8'h01);
      reg_check(epiu_pkg::OFS_EXT_FLAGS, 8'h00);
      epiu_pin_model_inst.set_ext(1'b1);
      settle();
      req_check(1'b0, epiu_pkg::VEC_NONE);
      check({7'h00, wake}, 8'h00);
      // edge codes, request held off by the mask bit
      reg_write(epiu_pkg::OFS_EXT_MASK, 8'h00);
      for (int c = 1; c < 4; c++) begin
         fall_hit = (c == 1 || c == 2);
         rise_hit = (c == 1 || c == 3);
         reg_write(epiu_pkg::OFS_EXT_SENSE, 8'(c));
         reg_write(epiu_pkg::OFS_EXT_FLAGS, 8'h01);
         epiu_pin_model_inst.set_ext(1'b0);
         settle();
         reg_check(epiu_pkg::OFS_EXT_FLAGS, {7'h00, fall_hit});
         reg_write(epiu_pkg::OFS_EXT_FLAGS, 8'h01);
         reg_check(epiu_pkg::OFS_EXT_FLAGS, 8'h00);
         epiu_pin_model_inst.set_ext(1'b1);
         settle();
         reg_check(epiu_pkg::OFS_EXT_FLAGS, {7'h00, rise_hit});
         check({7'h00, int_req}, 8'h00);
      end
      // one-cycle pulse, global enable gating, service clears flag
      reg_write(epiu_pkg::OFS_EXT_FLAGS, 8'h01);
      reg_write(epiu_pkg::OFS_EXT_MASK, 8'h01);
      gie <= 1'b0;
      epiu_pin_model_inst.set_ext(1'b0);
      epiu_pin_model_inst.set_ext(1'b1);
      settle();
      check({7'h00, int_req}, 8'h00);
      reg_check(epiu_pkg::OFS_EXT_FLAGS, 8'h01);
      @(posedge clk_sys_i);
      gie <= 1'b1;
      settle();
      req_check(1'b1, epiu_pkg::VEC_EXT_ZERO);
      service(epiu_pkg::VEC_EXT_ZERO);
      settle();
      reg_check(epiu_pkg::OFS_EXT_FLAGS, 8'h00);
      req_check(1'b0, epiu_pkg::VEC_NONE);
      // group zero: masked line ignored, unmasked line requests
      reg_write(epiu_pkg::OFS_PCHG_MASK0, 8'h01);
      reg_write(epiu_pkg::OFS_PCHG_ENABLE, 8'h01);
      epiu_pin_model_inst.toggle_line(1);
      settle();
      reg_check(epiu_pkg::OFS_PCHG_FLAGS, 8'h00);
      epiu_pin_model_inst.toggle_line(0);
      // sampled one edge later, wake stands for the one cycle after that
      repeat (2) @(posedge clk_sys_i);
      #1;
      check({7'h00, wake}, 8'h01);
      settle();
      reg_check(epiu_pkg::OFS_PCHG_FLAGS, 8'h01);
      req_check(1'b1, epiu_pkg::VEC_PCHG_ZERO);
      service(epiu_pkg::VEC_PCHG_ZERO);
      settle();
      reg_check(epiu_pkg::OFS_PCHG_FLAGS, 8'h00);
      // group one: bit 3 gates line 11, bit 2 cleared blocks line 10
      reg_write(epiu_pkg::OFS_PCHG_MASK1, 8'h08);
      reg_write(epiu_pkg::OFS_PCHG_ENABLE, 8'h03);
      epiu_pin_model_inst.toggle_line(10);
      settle();
      reg_check(epiu_pkg::OFS_PCHG_FLAGS, 8'h00);
      epiu_pin_model_inst.toggle_line(11);
      settle();
      req_check(1'b1, epiu_pkg::VEC_PCHG_ONE);
      reg_check(epiu_pkg::OFS_PCHG_FLAGS, 8'h02);
      reg_write(epiu_pkg::OFS_PCHG_FLAGS, 8'h02);
      reg_check(epiu_pkg::OFS_PCHG_FLAGS, 8'h00);
      settle();
      req_check(1'b0, epiu_pkg::VEC_NONE);
      // summary line: masked, unmasked, cleared by writing ones
      check({7'h00, irq}, 8'h00);
      reg_write(epiu_pkg::OFS_EVT_MASK, 8'h07);
      settle();
      check({7'h00, irq}, 8'h01);
      reg_write(epiu_pkg::OFS_EVT_STATUS, 8'h07);
      settle();
      check({7'h00, irq}, 8'h00);
      reg_check(epiu_pkg::OFS_EVT_STATUS, 8'h00);
      epiu_pin_model_inst.toggle_line(0);
      settle();
      check({7'h00, irq}, 8'h01);
      complete_run();
   end
endmodule : epiu_top_tb_top
